// ==== src/tcr_pkg.sv ====
package tcr_pkg;
    // Register word addresses (one register per word)
    localparam logic [3:0] ADDR_CTL0 = 4'h0;
    localparam logic [3:0] ADDR_CTL1 = 4'h1;
    localparam logic [3:0] ADDR_CNT_HI = 4'h2;
    localparam logic [3:0] ADDR_CNT_LO = 4'h3;
    localparam logic [3:0] ADDR_RLD_HI = 4'h4;
    localparam logic [3:0] ADDR_RLD_LO = 4'h5;
    localparam logic [3:0] ADDR_CAP_HI = 4'h6;
    localparam logic [3:0] ADDR_CAP_LO = 4'h7;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
    // Control zero fields
    localparam int CTL0_MODE_HI = 7;
    localparam int CTL0_SRC_HI = 6;
    localparam int CTL0_SRC_LO = 5;
    localparam int CTL0_CAUSE = 4;
    // Control one fields
    localparam int CTL1_EN = 7;
    localparam int CTL1_POL = 6;
    localparam int CTL1_PRE_HI = 5;
    localparam int CTL1_PRE_LO = 3;
    localparam int CTL1_MODE_HI = 2;
    localparam int CTL1_MODE_LO = 0;
    // Mode {high bit, low field} for capture-restart
    localparam logic [3:0] MODE_CAP_RESTART = 4'h9;
    // Interrupt source select
    localparam logic [1:0] SRC_BOTH = 2'h0;
    localparam logic [1:0] SRC_CAPTURE = 2'h2;
    localparam logic [1:0] SRC_RELOAD = 2'h3;
    // Status bits
    localparam int ST_CAP = 0;
    localparam int ST_RLD = 1;
    // Reset and restart values
    localparam logic [15:0] CNT_RESTART = 16'h0001;
    localparam logic [15:0] CNT_RESET = 16'h0001;
    localparam logic [15:0] RLD_RESET = 16'hFFFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : tcr_pkg

// ==== src/tcr_prescale.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcr_prescale (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Control
    input wire logic i_run,
    input wire logic i_clear,
    input wire logic [2:0] i_shift,
    // Tick
    output logic o_tick
);
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic [6:0] limit;
    always_comb begin
        limit = 7'((8'h01 << i_shift) - 8'h01);
        next_cnt = cnt;
        if (i_clear || !i_run) begin
            next_cnt = 7'h00;
        end else if (cnt >= limit) begin
            next_cnt = 7'h00;
        end else begin
            next_cnt = 7'(cnt + 7'h01);
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt <= 7'h00;
        end else begin
            cnt <= next_cnt;
        end
    end
    // One tick per prescale period
    assign o_tick = i_run && !i_clear && (cnt >= limit);
endmodule : tcr_prescale
`default_nettype wire

// ==== src/tcr_edge.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcr_edge (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Pin and polarity
    input wire logic i_pin,
    input wire logic i_rising,
    // Edge pulse
    output logic o_edge
);
    logic prev;
    logic next_prev;
    always_comb begin
        next_prev = i_pin;
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            // Follow the pin so no false edge follows reset
            prev <= i_pin;
        end else begin
            prev <= next_prev;
        end
    end
    assign o_edge = i_rising ? (i_pin && !prev) : (!i_pin && prev);
endmodule : tcr_edge
`default_nettype wire

// ==== src/tcr_timer.sv ====
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tcr_timer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Timer pins
    input wire logic i_timer_in,
    output logic o_timer_out,
    // Interrupt
    output logic o_irq
);
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] capture;
    logic [7:0] low_hold;
    logic armed;
    logic tout;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] rdata;
    logic ack;
    logic [7:0] next_ctl0;
    logic [7:0] next_ctl1;
    logic [15:0] next_count;
    logic [15:0] next_reload;
    logic [15:0] next_capture;
    logic [7:0] next_low_hold;
    logic next_armed;
    logic next_tout;
    logic [1:0] next_status;
    logic [1:0] next_mask;
    logic [31:0] next_rdata;
    logic next_ack;
    logic next_irq;
    logic next_waitreq;
    logic enabled;
    logic cap_mode;
    logic edge_hit;
    logic tick;
    logic wr;
    logic rd;
    logic cap_ev;
    logic rld_ev;
    logic [1:0] src;

    assign cap_mode = ({ctl0[tcr_pkg::CTL0_MODE_HI],
                        ctl1[tcr_pkg::CTL1_MODE_HI:tcr_pkg::CTL1_MODE_LO]} == tcr_pkg::MODE_CAP_RESTART);
    assign enabled = ctl1[tcr_pkg::CTL1_EN] && cap_mode;
    assign src = ctl0[tcr_pkg::CTL0_SRC_HI:tcr_pkg::CTL0_SRC_LO];
    assign wr = i_avs_write && !ack;
    assign rd = i_avs_read && !ack;

    tcr_edge u_edge (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_timer_in),
        .i_rising(ctl1[tcr_pkg::CTL1_POL]),
        .o_edge(edge_hit)
    );

    tcr_prescale u_pre (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_run(enabled && armed),
        .i_clear(cap_ev),
        .i_shift(ctl1[tcr_pkg::CTL1_PRE_HI:tcr_pkg::CTL1_PRE_LO]),
        .o_tick(tick)
    );

    assign cap_ev = enabled && armed && edge_hit;
    assign rld_ev = enabled && armed && !cap_ev && tick && (count == reload);

    always_comb begin
        next_ctl0 = ctl0;
        next_ctl1 = ctl1;
        next_count = count;
        next_reload = reload;
        next_capture = capture;
        next_low_hold = low_hold;
        next_armed = armed;
        next_tout = tout;
        next_status = status;
        next_mask = mask;
        next_rdata = rdata;
        next_ack = 1'b0;
        if (!enabled) begin
            next_armed = 1'b0;
        end else if (!armed && edge_hit) begin
            next_armed = 1'b1;
        end
        if (tick) begin
            next_count = 16'(count + 16'h0001);
        end
        if (cap_ev) begin
            next_capture = count;
            next_count = tcr_pkg::CNT_RESTART;
        end else if (rld_ev) begin
            next_count = tcr_pkg::CNT_RESTART;
        end
        if (cap_ev || rld_ev) begin
            next_tout = !tout;
        end
        if (wr) begin
            next_ack = 1'b1;
            case (i_avs_address)
                tcr_pkg::ADDR_CTL0: begin
                    next_ctl0 = i_avs_writedata[7:0];
                    next_ctl0[tcr_pkg::CTL0_CAUSE] = ctl0[tcr_pkg::CTL0_CAUSE];
                end
                tcr_pkg::ADDR_CTL1: next_ctl1 = i_avs_writedata[7:0];
                tcr_pkg::ADDR_CNT_HI: next_count[15:8] = i_avs_writedata[7:0];
                tcr_pkg::ADDR_CNT_LO: next_count[7:0] = i_avs_writedata[7:0];
                tcr_pkg::ADDR_RLD_HI: next_reload[15:8] = i_avs_writedata[7:0];
                tcr_pkg::ADDR_RLD_LO: next_reload[7:0] = i_avs_writedata[7:0];
                tcr_pkg::ADDR_CAP_HI: next_capture[15:8] = i_avs_writedata[7:0];
                tcr_pkg::ADDR_CAP_LO: next_capture[7:0] = i_avs_writedata[7:0];
                // Write one to clear, new event wins
                tcr_pkg::ADDR_IRQ_STAT: next_status = status & ~i_avs_writedata[1:0];
                tcr_pkg::ADDR_IRQ_MASK: next_mask = i_avs_writedata[1:0];
                default: next_ack = 1'b1;
            endcase
        end
        // Events outrank a software write
        if (cap_ev) begin
            next_ctl0[tcr_pkg::CTL0_CAUSE] = 1'b1;
        end else if (rld_ev) begin
            next_ctl0[tcr_pkg::CTL0_CAUSE] = 1'b0;
        end
        if (cap_ev && (src != tcr_pkg::SRC_RELOAD)) begin
            next_status[tcr_pkg::ST_CAP] = 1'b1;
        end
        if (rld_ev && (src != tcr_pkg::SRC_CAPTURE)) begin
            next_status[tcr_pkg::ST_RLD] = 1'b1;
        end
        if (rd) begin
            next_ack = 1'b1;
            next_rdata = 32'h0000_0000;
            case (i_avs_address)
                tcr_pkg::ADDR_CTL0: next_rdata[7:0] = ctl0;
                tcr_pkg::ADDR_CTL1: next_rdata[7:0] = ctl1;
                tcr_pkg::ADDR_CNT_HI: begin
                    next_rdata[7:0] = count[15:8];
                    next_low_hold = count[7:0];
                end
                tcr_pkg::ADDR_CNT_LO: next_rdata[7:0] = enabled ? low_hold : count[7:0];
                tcr_pkg::ADDR_RLD_HI: next_rdata[7:0] = reload[15:8];
                tcr_pkg::ADDR_RLD_LO: next_rdata[7:0] = reload[7:0];
                tcr_pkg::ADDR_CAP_HI: next_rdata[7:0] = capture[15:8];
                tcr_pkg::ADDR_CAP_LO: next_rdata[7:0] = capture[7:0];
                tcr_pkg::ADDR_IRQ_STAT: next_rdata[1:0] = status;
                tcr_pkg::ADDR_IRQ_MASK: next_rdata[1:0] = mask;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_irq = |(next_status & next_mask);
        next_waitreq = !next_ack;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctl0 <= tcr_pkg::BYTE_ZERO;
            ctl1 <= tcr_pkg::BYTE_ZERO;
            count <= tcr_pkg::CNT_RESET;
            reload <= tcr_pkg::RLD_RESET;
            capture <= 16'h0000;
            low_hold <= tcr_pkg::BYTE_ZERO;
            armed <= 1'b0;
            tout <= 1'b0;
            status <= 2'h0;
            mask <= 2'h0;
            rdata <= 32'h0000_0000;
            ack <= 1'b0;
            o_irq <= 1'b0;
            o_avs_waitrequest <= 1'b1;
        end else begin
            ctl0 <= next_ctl0;
            ctl1 <= next_ctl1;
            count <= next_count;
            reload <= next_reload;
            capture <= next_capture;
            low_hold <= next_low_hold;
            armed <= next_armed;
            tout <= next_tout;
            status <= next_status;
            mask <= next_mask;
            rdata <= next_rdata;
            ack <= next_ack;
            o_irq <= next_irq;
            o_avs_waitrequest <= next_waitreq;
        end
    end

    assign o_avs_readdata = rdata;
    assign o_timer_out = tout;

    property p_capture_store;
        @(posedge i_clk) disable iff (i_sys_rst)
        cap_ev && !wr |=> (capture == $past(count)) && (count == tcr_pkg::CNT_RESTART);
    endproperty
    a_capture_store: assert property (p_capture_store) else $error("capture not stored");
    property p_cause_set;
        @(posedge i_clk) disable iff (i_sys_rst)
        cap_ev && !wr |=> ctl0[tcr_pkg::CTL0_CAUSE];
    endproperty
    a_cause_set: assert property (p_cause_set) else $error("cause flag not set");
    property p_cause_clr;
        @(posedge i_clk) disable iff (i_sys_rst)
        rld_ev && !wr |=> !ctl0[tcr_pkg::CTL0_CAUSE] && count == tcr_pkg::CNT_RESTART;
    endproperty
    a_cause_clr: assert property (p_cause_clr) else $error("reload restart wrong");
    property p_first_edge;
        @(posedge i_clk) disable iff (i_sys_rst)
        enabled && !armed && edge_hit && !wr |=> armed && (status == $past(status));
    endproperty
    a_first_edge: assert property (p_first_edge) else $error("event before arming");
    property p_src;
        @(posedge i_clk) disable iff (i_sys_rst)
        rld_ev && src == tcr_pkg::SRC_CAPTURE && !status[tcr_pkg::ST_RLD] |=> !status[tcr_pkg::ST_RLD];
    endproperty
    a_src: assert property (p_src) else $error("reload irq not filtered");
    property p_toggle;
        @(posedge i_clk) disable iff (i_sys_rst)
        (cap_ev || rld_ev) |=> tout != $past(tout);
    endproperty
    a_toggle: assert property (p_toggle) else $error("output not toggled");
    property p_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        !enabled && !wr |=> count == $past(count);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled count moved");
    property p_irq;
        @(posedge i_clk) disable iff (i_sys_rst)
        cap_ev && (src != tcr_pkg::SRC_RELOAD) && mask[tcr_pkg::ST_CAP] && !wr |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("capture irq missing");
    property p_rld_irq;
        @(posedge i_clk) disable iff (i_sys_rst)
        rld_ev && (src != tcr_pkg::SRC_CAPTURE) && mask[tcr_pkg::ST_RLD] && !wr |=> o_irq;
    endproperty
    a_rld_irq: assert property (p_rld_irq) else $error("reload irq missing");
    property p_count_step;
        @(posedge i_clk) disable iff (i_sys_rst)
        tick && !cap_ev && !rld_ev && !wr |=> count == 16'($past(count) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step wrong");
    property p_low_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        rd && (i_avs_address == tcr_pkg::ADDR_CNT_HI) |=> low_hold == $past(count[7:0]);
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("low byte not latched");
    property p_wait;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
    c_cap: cover property (@(posedge i_clk) cap_ev);
    c_arm: cover property (@(posedge i_clk) enabled && !armed && edge_hit);
    c_rld: cover property (@(posedge i_clk) rld_ev);
    c_irq: cover property (@(posedge i_clk) o_irq);
endmodule : tcr_timer
`default_nettype wire

// ==== test/tcr_pin_src.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcr_pin_src (
    // Clock
    input wire logic i_clk,
    // Command
    input wire logic i_go,
    input wire logic i_rise,
    input wire logic [7:0] i_gap,
    // Pin and status
    output logic o_pin,
    output logic o_busy
);
    int left = 0;
    initial o_pin = 1'b0;
    // opposite edge first, then the active one
    always @(posedge i_clk) begin
        if (i_go) begin
            left <= int'(i_gap);
        end else if (left > 0) begin
            left <= left - 1;
        end
        if (left == 4) begin
            o_pin <= !i_rise;
        end
        if (left == 1) begin
            o_pin <= i_rise;
        end
    end
    assign o_busy = i_go || (left != 0);
endmodule : tcr_pin_src
`default_nettype wire

// ==== test/timer_capture_restart_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module timer_capture_restart_tb;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic pin;
    logic tmr_out;
    logic irq;
    logic go = 1'b0;
    logic rise = 1'b1;
    logic [7:0] gap = 8'h10;
    logic busy;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    tcr_timer dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_timer_in(pin), .o_timer_out(tmr_out), .o_irq(irq));
    tcr_pin_src src (.i_clk(i_clk), .i_go(go), .i_rise(rise), .i_gap(gap), .o_pin(pin), .o_busy(busy));
    task automatic wrap_up;
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge i_clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) begin
            failures++;
            wrap_up();
        end
    endtask : bus
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr8
    task automatic rd8(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask : rd8
    // Stamp is the cycle at which the pin takes its active level
    task automatic start(input logic r, input logic [7:0] g, output int stamp);
        rise <= r;
        gap <= g;
        go <= 1'b1;
        @(posedge i_clk);
        stamp = cyc + int'(g);
        go <= 1'b0;
    endtask : start
    task automatic finish_edge;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 300) begin
            failures++;
            wrap_up();
        end
    endtask : finish_edge
    task automatic t_reset;
        logic [31:0] q;
        rd8(tcr_pkg::ADDR_CNT_HI, q);
        chk(q, 32'h00);
        rd8(tcr_pkg::ADDR_CNT_LO, q);
        chk(q, 32'h01);
        rd8(tcr_pkg::ADDR_RLD_HI, q);
        chk(q, 32'hFF);
        rd8(tcr_pkg::ADDR_RLD_LO, q);
        chk(q, 32'hFF);
        // Unmapped place reads zero
        rd8(4'hA, q);
        chk(q, 32'h00);
        chk({31'h0, irq}, 32'h0);
    endtask : t_reset
    task automatic t_setup(input logic [7:0] dis, input logic [7:0] en);
        wr8(tcr_pkg::ADDR_CTL1, dis);
        wr8(tcr_pkg::ADDR_CTL0, 8'h80);
        wr8(tcr_pkg::ADDR_CNT_HI, 8'h00);
        wr8(tcr_pkg::ADDR_CNT_LO, 8'h01);
        wr8(tcr_pkg::ADDR_RLD_HI, 8'hFF);
        wr8(tcr_pkg::ADDR_RLD_LO, 8'hFF);
        wr8(tcr_pkg::ADDR_IRQ_MASK, 8'h03);
        wr8(tcr_pkg::ADDR_CTL1, en);
    endtask : t_setup
    // Each capture holds the spacing of two accepted edges, in prescaled counts
    task automatic t_capture(input logic r, input logic [7:0] g1, input logic [7:0] g2, input int pre);
        logic [31:0] q;
        logic [31:0] c1;
        int e0;
        int e1;
        int e2;
        start(r, 8'd30, e0);
        finish_edge();
        start(r, g1, e1);
        repeat (8) @(posedge i_clk);
        rd8(tcr_pkg::ADDR_IRQ_STAT, q);
        chk(q, 32'h0);
        finish_edge();
        start(r, g2, e2);
        repeat (8) @(posedge i_clk);
        rd8(tcr_pkg::ADDR_CAP_HI, q);
        rd8(tcr_pkg::ADDR_CAP_LO, c1);
        c1 = {16'h0, q[7:0], c1[7:0]};
        chk(c1, 1 + (e1 - e0 - 1) / pre);
        chk({31'h0, irq}, 32'h1);
        rd8(tcr_pkg::ADDR_IRQ_STAT, q);
        chk(q, 32'h1);
        rd8(tcr_pkg::ADDR_CTL0, q);
        chk({31'h0, q[4]}, 32'h1);
        wr8(tcr_pkg::ADDR_IRQ_STAT, 8'h01);
        repeat (2) @(posedge i_clk);
        chk({31'h0, irq}, 32'h0);
        finish_edge();
        repeat (8) @(posedge i_clk);
        rd8(tcr_pkg::ADDR_CAP_HI, q);
        rd8(tcr_pkg::ADDR_CAP_LO, c1);
        chk({16'h0, q[7:0], c1[7:0]}, 1 + (e2 - e1 - 1) / pre);
        wr8(tcr_pkg::ADDR_IRQ_STAT, 8'h03);
    endtask : t_capture
    task automatic t_reload;
        logic [31:0] q;
        logic [31:0] q2;
        logic t0;
        int n;
        wr8(tcr_pkg::ADDR_CTL1, 8'h41);
        wr8(tcr_pkg::ADDR_RLD_HI, 8'h00);
        wr8(tcr_pkg::ADDR_RLD_LO, 8'h40);
        wr8(tcr_pkg::ADDR_CTL1, 8'hC1);
        start(1'b1, 8'd10, n);
        finish_edge();
        repeat (4) @(posedge i_clk);
        t0 = tmr_out;
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 200) begin
            failures++;
            wrap_up();
        end
        chk({31'h0, tmr_out}, {31'h0, ~t0});
        chk({31'h0, irq}, 32'h1);
        rd8(tcr_pkg::ADDR_IRQ_STAT, q);
        chk(q, 32'h2);
        rd8(tcr_pkg::ADDR_CTL0, q);
        chk({31'h0, q[4]}, 32'h0);
        // Capture-only source must hide reload events
        wr8(tcr_pkg::ADDR_CTL0, 8'hC0);
        wr8(tcr_pkg::ADDR_IRQ_STAT, 8'h03);
        n = 0;
        repeat (150) begin
            @(posedge i_clk);
            n += int'(irq === 1'b1);
        end
        chk(n, 0);
        // Live count would move between the two low reads
        rd8(tcr_pkg::ADDR_CNT_HI, q2);
        chk(q2, 32'h0);
        repeat (5) @(posedge i_clk);
        rd8(tcr_pkg::ADDR_CNT_LO, q);
        rd8(tcr_pkg::ADDR_CNT_LO, q2);
        chk(q2, q);
        // Reload-only source must hide captures
        wr8(tcr_pkg::ADDR_CTL0, 8'hE0);
        wr8(tcr_pkg::ADDR_IRQ_STAT, 8'h03);
        start(1'b1, 8'd10, n);
        finish_edge();
        repeat (2) @(posedge i_clk);
        rd8(tcr_pkg::ADDR_IRQ_STAT, q);
        chk({31'h0, q[tcr_pkg::ST_CAP]}, 32'h0);
        rd8(tcr_pkg::ADDR_CTL0, q);
        chk({31'h0, q[tcr_pkg::CTL0_CAUSE]}, 32'h1);
        wr8(tcr_pkg::ADDR_CTL1, 8'h41);
        rd8(tcr_pkg::ADDR_CNT_LO, q);
        repeat (20) @(posedge i_clk);
        rd8(tcr_pkg::ADDR_CNT_LO, q2);
        chk(q2, q);
        wr8(tcr_pkg::ADDR_CNT_LO, 8'h5A);
        rd8(tcr_pkg::ADDR_CNT_LO, q);
        chk(q, 32'h5A);
    endtask : t_reload
    initial begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_reset();
        t_setup(8'h41, 8'hC1);
        t_capture(1'b1, 8'd20, 8'd50, 1);
        t_setup(8'h11, 8'h91);
        t_capture(1'b0, 8'd40, 8'd80, 4);
        t_reload();
        wrap_up();
    end
endmodule : timer_capture_restart_tb
`default_nettype wire
